// file: rtl/salf_bufpool.sv
// shared frame buffer pool accounting
`timescale 1ns/1ps
`default_nettype none
module salf_bufpool (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          nrst,
	// allocation from the forwarding engine
	input  wire logic                          alloc,
	input  wire logic [salf_pkg::NBUF_W-1:0]   alloc_n,
	// release from transmit queues
	input  wire logic                          rel,
	input  wire logic [salf_pkg::NBUF_W-1:0]   rel_n,
	// state
	output logic      [salf_pkg::BUFCNT_W-1:0] free_reg
);
	logic [salf_pkg::BUFCNT_W-1:0] free_next;

	// whole buffers only; count never exceeds the pool
	always_comb begin
		free_next = free_reg;
		if (alloc)
			free_next = free_next - salf_pkg::BUFCNT_W'(alloc_n);
		if (rel)
			free_next = free_next + salf_pkg::BUFCNT_W'(rel_n);
		if (free_next > salf_pkg::BUFCNT_W'(salf_pkg::NBUF))
			free_next = salf_pkg::BUFCNT_W'(salf_pkg::NBUF);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			free_reg <= salf_pkg::BUFCNT_W'(salf_pkg::NBUF);
		else
			free_reg <= free_next;
	end
endmodule
`default_nettype wire

// file: rtl/salf_engine.sv
// address learning, aging and two-stage forwarding engine
`timescale 1ns/1ps
`default_nettype none
module salf_engine #(
	parameter longint AGE_EPOCH_CYCLES = salf_pkg::AGE_EPOCH_CYC
) (
	// clock and reset
	input  wire logic                                  MCLK,
	input  wire logic                                  NRST,
	// end-of-frame descriptors from receive MACs
	input  wire logic                                  DESC_VALID,
	input  wire salf_pkg::salf_desc_s                  DESC,
	output logic                                       DESC_READY,
	// configuration
	input  wire logic                                  AGE_EN,
	input  wire logic [salf_pkg::NPORT-1:0]            STP_FWD,
	input  wire logic [salf_pkg::NPORT-1:0]            MIRROR_RX,
	input  wire logic [salf_pkg::NPORT-1:0]            MIRROR_TX,
	input  wire logic [salf_pkg::NPORT-1:0]            SNIFF_PORTS,
	input  wire logic [salf_pkg::NPORT-1:0]            ROUTER_PORTS,
	input  wire logic [salf_pkg::NPORT-1:0]            AUTH_EN,
	input  wire logic [salf_pkg::NPORT*salf_pkg::NPORT-1:0] PORT_VLAN,
	input  wire salf_pkg::salf_static_s [salf_pkg::NSTATIC-1:0] STATIC_TBL,
	// buffer release from transmit queues
	input  wire logic                                  REL_VALID,
	input  wire logic [salf_pkg::NBUF_W-1:0]           REL_NBUF,
	// forwarding result
	output logic                                       FWD_VALID,
	output salf_pkg::salf_fwd_s                        FWD,
	output logic                                       DROP,
	// flow control towards receive ports
	output logic                                       PAUSE_VALID,
	output salf_pkg::salf_pause_s                      PAUSE,
	// status
	output logic [salf_pkg::BUFCNT_W-1:0]              FREE_BUFS
);
	typedef enum logic [1:0] {S_IDLE, S_SCAN, S_DECIDE} salf_state_e;

	salf_state_e                    state_reg;
	salf_pkg::salf_desc_s           desc_reg;
	logic [47:0]                    tbl_mac [salf_pkg::TBL_DEPTH];
	logic [salf_pkg::PORT_W-1:0]    tbl_port [salf_pkg::TBL_DEPTH];
	logic [salf_pkg::STAMP_W-1:0]   tbl_stamp [salf_pkg::TBL_DEPTH];
	logic [salf_pkg::TBL_DEPTH-1:0] tbl_valid_reg;
	logic [salf_pkg::TBL_AW-1:0]    scan_reg;
	logic [salf_pkg::TBL_AW-1:0]    age_ptr_reg;
	logic                           sa_hit_reg;
	logic [salf_pkg::TBL_AW-1:0]    sa_idx_reg;
	logic                           da_hit_reg;
	logic [salf_pkg::PORT_W-1:0]    da_port_reg;
	logic                           free_hit_reg;
	logic [salf_pkg::TBL_AW-1:0]    free_idx_reg;
	logic [63:0]                    epoch_cnt_reg;
	logic [salf_pkg::STAMP_W-1:0]   now_reg;
	logic [salf_pkg::BUFCNT_W-1:0]  free_bufs;

	////////////////////////////////////////////////////////////////////////
	// frame qualification and buffer need

	logic                           good;
	logic [salf_pkg::NBUF_W-1:0]    nbuf;
	logic [salf_pkg::LEN_W:0]       len_up;

	always_comb begin
		good = !desc_reg.err_rx && !desc_reg.err_fcs && !desc_reg.err_align
			&& desc_reg.len >= salf_pkg::LEN_W'(salf_pkg::MIN_LEN)
			&& desc_reg.len <= salf_pkg::LEN_W'(salf_pkg::MAX_LEN);
		len_up = {1'b0, desc_reg.len} + (salf_pkg::LEN_W+1)'(salf_pkg::BUF_BYTES - 1);
		nbuf = salf_pkg::NBUF_W'(len_up >> salf_pkg::BUF_SHIFT);
	end

	////////////////////////////////////////////////////////////////////////
	// stage one: VLAN, static and dynamic destination lookup

	logic [salf_pkg::NPORT-1:0] src_mask;
	logic [salf_pkg::NPORT-1:0] first_stage_port_set;
	logic                       static_hit;
	logic [salf_pkg::NPORT-1:0] static_ports;
	logic                       local_frame;

	always_comb begin
		src_mask = salf_pkg::NPORT'(1) << desc_reg.port;
		static_hit = 1'b0;
		static_ports = '0;
		for (int i = 0; i < salf_pkg::NSTATIC; i++) begin
			if (!static_hit && STATIC_TBL[i].valid && STATIC_TBL[i].mac == desc_reg.da) begin
				static_hit = 1'b1;
				static_ports = STATIC_TBL[i].ports;
			end
		end
		local_frame = 1'b0;
		if (desc_reg.da[salf_pkg::MCAST_BIT])
			first_stage_port_set = ~src_mask;
		else if (static_hit)
			first_stage_port_set = static_ports;
		else if (da_hit_reg) begin
			first_stage_port_set = salf_pkg::NPORT'(1) << da_port_reg;
			local_frame = da_port_reg == desc_reg.port;
		end else
			first_stage_port_set = ~src_mask;
		first_stage_port_set = first_stage_port_set & desc_reg.vid_ports;
	end

	////////////////////////////////////////////////////////////////////////
	// stage two: spanning tree, IGMP, mirroring, port VLAN, authentication

	logic [salf_pkg::NPORT-1:0] stage_two;
	logic [salf_pkg::NPORT-1:0] final_port_set;
	logic [salf_pkg::NPORT-1:0] src_vlan;

	assign src_vlan = PORT_VLAN[desc_reg.port*salf_pkg::NPORT +: salf_pkg::NPORT];

	genvar g;
	generate
		for (g = 0; g < salf_pkg::NPORT; g++) begin : g_port
			logic cand;
			assign cand = desc_reg.igmp ? ROUTER_PORTS[g] : first_stage_port_set[g];
			assign stage_two[g] = cand && STP_FWD[g] && src_vlan[g] && !src_mask[g];
		end
	endgenerate

	always_comb begin
		final_port_set = stage_two;
		if ((MIRROR_RX & src_mask) != '0 || (MIRROR_TX & stage_two) != '0)
			final_port_set = final_port_set | (SNIFF_PORTS & ~src_mask);
		if (!STP_FWD[desc_reg.port] || (AUTH_EN[desc_reg.port] && !desc_reg.authed))
			final_port_set = '0;
		if (desc_reg.acl_hit)
			final_port_set = desc_reg.acl_ports & ~src_mask;
	end

	logic fwd_ok;
	assign fwd_ok = good && !desc_reg.is_pause && (!local_frame || desc_reg.acl_hit) && final_port_set != '0
		&& free_bufs >= salf_pkg::BUFCNT_W'(nbuf);

	////////////////////////////////////////////////////////////////////////
	// control sequence: idle, table scan, decision

	// descriptor arrives only at end of frame, after it is fully buffered
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			state_reg <= S_IDLE;
			scan_reg <= '0;
		end else begin
			case (state_reg)
				S_IDLE: begin
					scan_reg <= '0;
					if (DESC_VALID)
						state_reg <= S_SCAN;
				end
				S_SCAN: begin
					scan_reg <= scan_reg + 10'h001;
					if (scan_reg == salf_pkg::TBL_AW'(salf_pkg::LAST_ENTRY))
						state_reg <= S_DECIDE;
				end
				S_DECIDE: state_reg <= S_IDLE;
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (state_reg == S_IDLE && DESC_VALID)
			desc_reg <= DESC;
	end

	// one entry per cycle: source hit, destination hit, first free slot
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			sa_hit_reg <= 1'b0;
			sa_idx_reg <= '0;
			da_hit_reg <= 1'b0;
			da_port_reg <= '0;
			free_hit_reg <= 1'b0;
			free_idx_reg <= '0;
		end else if (state_reg == S_IDLE) begin
			sa_hit_reg <= 1'b0;
			da_hit_reg <= 1'b0;
			free_hit_reg <= 1'b0;
		end else if (state_reg == S_SCAN) begin
			if (tbl_valid_reg[scan_reg] && tbl_mac[scan_reg] == desc_reg.sa) begin
				sa_hit_reg <= 1'b1;
				sa_idx_reg <= scan_reg;
			end
			if (tbl_valid_reg[scan_reg] && tbl_mac[scan_reg] == desc_reg.da) begin
				da_hit_reg <= 1'b1;
				da_port_reg <= tbl_port[scan_reg];
			end
			if (!tbl_valid_reg[scan_reg] && !free_hit_reg) begin
				free_hit_reg <= 1'b1;
				free_idx_reg <= scan_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// table update: learning, migration, refresh, aging

	logic                         learn;
	logic [salf_pkg::TBL_AW-1:0]  learn_idx;
	logic                         age_out;

	// table written by learning only once final status is known, good frames only; aging clears entries in idle
	assign learn = state_reg == S_DECIDE && good;
	assign learn_idx = sa_hit_reg ? sa_idx_reg
		: (free_hit_reg ? free_idx_reg : salf_pkg::TBL_AW'(salf_pkg::LAST_ENTRY));
	assign age_out = state_reg == S_IDLE && AGE_EN && tbl_valid_reg[age_ptr_reg]
		&& (now_reg - tbl_stamp[age_ptr_reg]) >= salf_pkg::AGE_LIMIT;

	always_ff @(posedge MCLK) begin
		if (learn) begin
			tbl_mac[learn_idx] <= desc_reg.sa;
			tbl_port[learn_idx] <= desc_reg.port;
			tbl_stamp[learn_idx] <= now_reg;
		end
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST)
			tbl_valid_reg <= '0;
		else if (learn)
			tbl_valid_reg[learn_idx] <= 1'b1;
		else if (age_out)
			tbl_valid_reg[age_ptr_reg] <= 1'b0;
	end

	// background sweep while no frame is being resolved
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST)
			age_ptr_reg <= '0;
		else if (state_reg == S_IDLE)
			age_ptr_reg <= age_ptr_reg + 10'h001;
	end

	// free-running coarse time base
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			epoch_cnt_reg <= '0;
			now_reg <= '0;
		end else if (epoch_cnt_reg >= 64'(AGE_EPOCH_CYCLES - 1)) begin
			epoch_cnt_reg <= '0;
			now_reg <= now_reg + 3'h1;
		end else
			epoch_cnt_reg <= epoch_cnt_reg + 64'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			FWD_VALID <= 1'b0;
			FWD <= '0;
			DROP <= 1'b0;
			PAUSE_VALID <= 1'b0;
			PAUSE <= '0;
		end else begin
			FWD_VALID <= state_reg == S_DECIDE && fwd_ok;
			DROP <= state_reg == S_DECIDE && !fwd_ok;
			PAUSE_VALID <= state_reg == S_DECIDE && good && desc_reg.is_pause;
			if (state_reg == S_DECIDE) begin
				FWD.ports <= final_port_set;
				FWD.src_port <= desc_reg.port;
				FWD.nbuf <= nbuf;
				PAUSE.port <= desc_reg.port;
				PAUSE.quanta <= desc_reg.pause_time;
			end
		end
	end

	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			DESC_READY <= 1'b0;
			FREE_BUFS <= salf_pkg::BUFCNT_W'(salf_pkg::NBUF);
		end else begin
			DESC_READY <= state_reg == S_IDLE && !DESC_VALID;
			FREE_BUFS <= free_bufs;
		end
	end

	salf_bufpool u_pool (
		.clk      (MCLK),
		.nrst     (NRST),
		.alloc    (state_reg == S_DECIDE && fwd_ok),
		.alloc_n  (nbuf),
		.rel      (REL_VALID),
		.rel_n    (REL_NBUF),
		.free_reg (free_bufs)
	);
endmodule
`default_nettype wire

// file: rtl/salf_pkg.sv
// shared constants and types of the address look-up and forwarding engine
// Contract
// - learn only absent source address from good frames
// - store address, ingress port and time stamp
// - table full: delete last entry, then write
// - known address on other port: overwrite port
// - matching source address refreshes time stamp
// - background aging removes entries after 300s +/-75s
// - one global bit turns aging on or off
// - stage one: VLAN, static, dynamic lookup
// - stage two: STP, IGMP, mirror, VLAN, authentication
// - ACL result overrides every other port set
// - errored or illegal-size frames are never forwarded
// - pause frames consumed, flow control applied instead
// - drop frame whose lookup port is ingress
// - whole frame stored before any forwarding
// - shared pool of 512 buffers, 128 bytes
// - 1K dynamic entries, all of them learnable
// - frames under 64 bytes are illegal length
package salf_pkg;
	localparam int NPORT        = 5;
	localparam int PORT_W       = 3;
	localparam int TBL_DEPTH    = 1024;
	localparam int TBL_AW       = 10;
	localparam int LAST_ENTRY   = 1023;
	localparam int NBUF         = 512;
	localparam int BUF_BYTES    = 128;
	localparam int BUF_SHIFT    = 7;
	localparam int BUFCNT_W     = 10;
	localparam int NBUF_W       = 5;
	localparam int LEN_W        = 12;
	localparam int MIN_LEN      = 64;
	localparam int MAX_LEN      = 2048;
	localparam int NSTATIC      = 4;
	localparam int MCAST_BIT    = 40;
	// aging: coarse epoch of 75 s, entry removed after 4 epochs
	localparam int CLK_MHZ      = 250;
	localparam longint AGE_EPOCH_S = 75;
	localparam longint AGE_EPOCH_CYC = AGE_EPOCH_S * 1000000 * CLK_MHZ;
	localparam int STAMP_W      = 3;
	localparam logic [STAMP_W-1:0] AGE_LIMIT = 3'h4;

	typedef struct packed {
		logic [47:0]       sa;
		logic [47:0]       da;
		logic [PORT_W-1:0] port;
		logic [LEN_W-1:0]  len;
		logic              err_rx;
		logic              err_fcs;
		logic              err_align;
		logic              is_pause;
		logic [15:0]       pause_time;
		logic [NPORT-1:0]  vid_ports;
		logic              igmp;
		logic              authed;
		logic              acl_hit;
		logic [NPORT-1:0]  acl_ports;
	} salf_desc_s;

	typedef struct packed {
		logic              valid;
		logic [47:0]       mac;
		logic [NPORT-1:0]  ports;
	} salf_static_s;

	typedef struct packed {
		logic [NPORT-1:0]  ports;
		logic [PORT_W-1:0] src_port;
		logic [NBUF_W-1:0] nbuf;
	} salf_fwd_s;

	typedef struct packed {
		logic [PORT_W-1:0] port;
		logic [15:0]       quanta;
	} salf_pause_s;
endpackage

// file: testbench/salf_engine_assertions.sv
// checker of the look-up and forwarding engine ports
`timescale 1ns/1ps
`default_nettype none
module salf_chk (
	// clock and reset
	input wire logic                          MCLK,
	input wire logic                          NRST,
	// descriptors
	input wire logic                          DESC_VALID,
	input wire salf_pkg::salf_desc_s          DESC,
	input wire logic                          DESC_READY,
	// results
	input wire logic                          FWD_VALID,
	input wire salf_pkg::salf_fwd_s           FWD,
	input wire logic                          DROP,
	input wire logic                          PAUSE_VALID,
	input wire salf_pkg::salf_pause_s         PAUSE,
	input wire logic [salf_pkg::BUFCNT_W-1:0] FREE_BUFS
);
	logic [10:0]         cnt_reg;
	salf_pkg::salf_desc_s d_reg;
	logic                bad;
	logic [4:0]          aclp;
	assign bad = d_reg.err_rx | d_reg.err_fcs | d_reg.err_align | (d_reg.len < 12'h040) | (d_reg.len > 12'h800);
	assign aclp = d_reg.acl_ports & ~(5'h01 << d_reg.port);
	// cycles since the descriptor was taken
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST)
			cnt_reg <= 11'h000;
		else if (DESC_VALID && DESC_READY)
			cnt_reg <= 11'h001;
		else if (cnt_reg != 11'h000 && cnt_reg < 11'h406)
			cnt_reg <= cnt_reg + 11'h001;
	end
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST)
			d_reg <= '0;
		else if (DESC_VALID && DESC_READY)
			d_reg <= DESC;
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (!NRST);
	sequence s_take; DESC_VALID && DESC_READY; endsequence
	sequence s_answer; cnt_reg == 11'h402; endsequence
	property p_busy; s_take |=> !DESC_READY [*8]; endproperty
	property p_quiet; (cnt_reg != 11'h000 && cnt_reg < 11'h402) |-> !FWD_VALID && !DROP && !PAUSE_VALID; endproperty
	property p_answer; s_answer |-> FWD_VALID != DROP; endproperty
	property p_bad; s_answer ##0 bad |-> DROP && !PAUSE_VALID; endproperty
	property p_pause; s_answer ##0 (!bad && d_reg.is_pause) |-> DROP && PAUSE_VALID
		&& PAUSE == {d_reg.port, d_reg.pause_time}; endproperty
	property p_self; FWD_VALID |-> (FWD.ports & (5'h01 << FWD.src_port)) == 5'h00; endproperty
	property p_nbuf; FWD_VALID |-> FWD.src_port == d_reg.port && FWD.nbuf == 5'((13'(d_reg.len) + 13'h07F) >> 7);
	endproperty
	property p_acl; s_answer ##0 (!bad && !d_reg.is_pause && d_reg.acl_hit && aclp != 5'h00 && FREE_BUFS >= 10'h010)
		|-> FWD_VALID && FWD.ports == aclp; endproperty
	property p_ready; DESC_READY |-> !$past(DESC_VALID); endproperty
	a_busy: assert property (p_busy) else $error("taken while busy");
	a_quiet: assert property (p_quiet) else $error("early result");
	a_answer: assert property (p_answer) else $error("no single result");
	a_bad: assert property (p_bad) else $error("errored frame not dropped");
	a_pause: assert property (p_pause) else $error("pause frame mishandled");
	a_self: assert property (p_self) else $error("sent back to ingress");
	a_nbuf: assert property (p_nbuf) else $error("buffer count wrong");
	a_acl: assert property (p_acl) else $error("access list not applied");
	a_ready: assert property (p_ready) else $error("ready while valid held");
endmodule
bind salf_engine salf_chk u_salf_chk (.MCLK(MCLK), .NRST(NRST), .DESC_VALID(DESC_VALID), .DESC(DESC),
	.DESC_READY(DESC_READY), .FWD_VALID(FWD_VALID), .FWD(FWD), .DROP(DROP), .PAUSE_VALID(PAUSE_VALID),
	.PAUSE(PAUSE), .FREE_BUFS(FREE_BUFS));
`default_nettype wire

// file: testbench/salf_engine_tb.sv
// self-checking bench of the look-up and forwarding engine
`timescale 1ns/1ps
`default_nettype none
module salf_engine_tb;
	localparam logic [47:0] BC = 48'hFFFFFFFFFFFF;
	localparam logic [47:0] ST_A = 48'h02000000000A;
	localparam logic [47:0] ST_B = 48'h02000000000B;
	localparam logic [47:0] ST_C = 48'h02000000000C;
	logic mclk, nrst, go, rel_go, age_en, desc_valid, desc_ready, rel_valid, fwd_valid, drop, pause_valid;
	logic [4:0]            rel_n, rel_nbuf, stp_fwd, mirror_rx, mirror_tx, sniff, router, auth_en;
	logic [24:0]           port_vlan;
	salf_pkg::salf_static_s [salf_pkg::NSTATIC-1:0] static_tbl;
	logic [9:0]            free_bufs;
	logic [30:0]           got;
	logic [30:0]           exp_q[$];
	salf_pkg::salf_desc_s  d_in, desc, td;
	salf_pkg::salf_fwd_s   fwd;
	salf_pkg::salf_pause_s pause;
	integer                seed, err_count, cmp_count, answered;
	always #2 mclk = ~mclk;
	salf_engine #(.AGE_EPOCH_CYCLES(64'h7D0)) u_salf_engine (.MCLK(mclk), .NRST(nrst), .DESC_VALID(desc_valid),
		.DESC(desc), .DESC_READY(desc_ready), .AGE_EN(age_en), .STP_FWD(stp_fwd), .MIRROR_RX(mirror_rx),
		.MIRROR_TX(mirror_tx), .SNIFF_PORTS(sniff), .ROUTER_PORTS(router), .AUTH_EN(auth_en),
		.PORT_VLAN(port_vlan), .STATIC_TBL(static_tbl), .REL_VALID(rel_valid), .REL_NBUF(rel_nbuf),
		.FWD_VALID(fwd_valid), .FWD(fwd),
		.DROP(drop), .PAUSE_VALID(pause_valid), .PAUSE(pause), .FREE_BUFS(free_bufs));
	salf_mac_model u_salf_mac_model (.mclk(mclk), .nrst(nrst), .go(go), .d_in(d_in), .rel_go(rel_go),
		.rel_n(rel_n), .desc_ready(desc_ready), .desc_valid(desc_valid), .desc(desc), .rel_valid(rel_valid),
		.rel_nbuf(rel_nbuf));
	task automatic wrap_up();
		if (err_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [30:0] seen, input logic [30:0] want);
		cmp_count++;
		if (seen !== want) begin
			err_count++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask
	function automatic salf_pkg::salf_desc_s mk(input logic [47:0] sa, input logic [47:0] da, input logic [2:0] p);
		salf_pkg::salf_desc_s d;
		d = '0;
		d.sa = sa;
		d.da = da;
		d.port = p;
		d.len = 12'h040 + 12'($unsigned($random(seed)) % 1985);
		d.vid_ports = 5'h1F;
		d.authed = 1'b1;
		return d;
	endfunction
	// one frame, expected result queued, then buffers handed back
	task automatic send(input salf_pkg::salf_desc_s d, input logic dr, input logic [4:0] pt);
		int n;
		logic [4:0] nb;
		nb = 5'((13'(d.len) + 13'h07F) >> 7);
		n = answered;
		exp_q.push_back({dr, dr ? 10'h000 : {pt, nb}, d.is_pause, d.is_pause ? {d.port, d.pause_time} : 19'h0});
		go = 1'b1;
		d_in = d;
		@(negedge mclk);
		go = 1'b0;
		for (int i = 0; i < 1200 && answered == n; i++)
			@(negedge mclk);
		if (answered == n) begin
			err_count++;
			wrap_up();
		end
		repeat (3) @(negedge mclk);
		check({21'h0, free_bufs}, {21'h0, 10'h200 - (dr ? 10'h000 : 10'(nb))});
		rel_go = !dr;
		rel_n = nb;
		@(negedge mclk);
		rel_go = 1'b0;
		repeat (3) @(negedge mclk);
		check({21'h0, free_bufs}, {21'h0, 10'h200});
	endtask
	always @(negedge mclk) begin
		if (nrst && (fwd_valid || drop)) begin
			got = {drop, fwd_valid ? {fwd.ports, fwd.nbuf} : 10'h000, pause_valid, pause_valid ? pause : 19'h0};
			answered++;
			check(got, exp_q.size() > 0 ? exp_q.pop_front() : ~got);
		end
	end
	initial begin
		{mclk, nrst, go, rel_go, rel_n, age_en, mirror_rx, mirror_tx, sniff, router, auth_en} = '0;
		port_vlan = '1;
		static_tbl = '0;
		{err_count, cmp_count, answered} = '0;
		d_in = '0;
		stp_fwd = 5'h1F;
		seed = 32'hb09b;
		repeat (2) @(negedge mclk);
		nrst = 1'b1;
		@(negedge mclk);
		send(mk(ST_A, BC, 3'h1), 1'b0, 5'h1D);
		send(mk(ST_C, ST_A, 3'h3), 1'b0, 5'h02);
		send(mk(ST_C, ST_A, 3'h1), 1'b1, 5'h00);
		td = mk(ST_A, BC, 3'h4);
		td.err_fcs = 1'b1;
		send(td, 1'b1, 5'h00);
		send(mk(ST_C, ST_A, 3'h3), 1'b0, 5'h02);
		td = mk(ST_B, BC, 3'h0);
		td.len = 12'h03F;
		send(td, 1'b1, 5'h00);
		send(mk(ST_C, ST_B, 3'h3), 1'b0, 5'h17);
		send(mk(ST_A, BC, 3'h4), 1'b0, 5'h0F);
		send(mk(ST_C, ST_A, 3'h0), 1'b0, 5'h10);
		stp_fwd = 5'h1A;
		td = mk(ST_C, ST_A, 3'h0);
		td.acl_hit = 1'b1;
		td.acl_ports = 5'h0F;
		send(td, 1'b0, 5'h0E);
		send(mk(ST_C, BC, 3'h2), 1'b1, 5'h00);
		stp_fwd = 5'h1F;
		auth_en = 5'h01;
		td = mk(ST_C, BC, 3'h0);
		td.authed = 1'b0;
		send(td, 1'b1, 5'h00);
		mirror_rx = 5'h08;
		sniff = 5'h01;
		send(mk(ST_C, ST_A, 3'h3), 1'b0, 5'h11);
		td = mk(ST_B, BC, 3'h2);
		td.is_pause = 1'b1;
		td.pause_time = 16'h1234;
		send(td, 1'b1, 5'h00);
		mirror_rx = 5'h00;
		static_tbl[1] = {1'b1, ST_B, 5'h06};
		send(mk(ST_C, ST_B, 3'h3), 1'b0, 5'h06);
		static_tbl = '0;
		router = 5'h05;
		td = mk(ST_C, BC, 3'h3);
		td.igmp = 1'b1;
		send(td, 1'b0, 5'h05);
		port_vlan[15 +: 5] = 5'h0C;
		mirror_tx = 5'h04;
		send(mk(ST_C, BC, 3'h3), 1'b0, 5'h05);
		port_vlan = '1;
		mirror_tx = 5'h00;
		td = mk(ST_C, ST_A, 3'h4);
		td.acl_hit = 1'b1;
		td.acl_ports = 5'h03;
		send(td, 1'b0, 5'h03);
		repeat (11000) @(negedge mclk);
		send(mk(ST_C, ST_A, 3'h0), 1'b0, 5'h10);
		age_en = 1'b1;
		repeat (11000) @(negedge mclk);
		send(mk(ST_C, ST_A, 3'h0), 1'b0, 5'h1E);
		wrap_up();
	end
endmodule
`default_nettype wire

// file: testbench/salf_mac_model.sv
// receive and transmit side model feeding descriptors and releases
`timescale 1ns/1ps
`default_nettype none
module salf_mac_model (
	// clock and reset
	input  wire logic                        mclk,
	input  wire logic                        nrst,
	// requests from the bench
	input  wire logic                        go,
	input  wire salf_pkg::salf_desc_s        d_in,
	input  wire logic                        rel_go,
	input  wire logic [salf_pkg::NBUF_W-1:0] rel_n,
	// engine side
	input  wire logic                        desc_ready,
	output logic                             desc_valid,
	output salf_pkg::salf_desc_s             desc,
	output logic                             rel_valid,
	output logic      [salf_pkg::NBUF_W-1:0] rel_nbuf
);
	// released bus shows inverted data
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			desc_valid <= 1'b0;
			desc       <= '0;
		end else if (desc_valid && desc_ready) begin
			desc_valid <= 1'b0;
			desc       <= ~desc;
		end else if (go && !desc_valid) begin
			desc_valid <= 1'b1;
			desc       <= d_in;
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rel_valid <= 1'b0;
			rel_nbuf  <= 5'h00;
		end else begin
			rel_valid <= rel_go;
			rel_nbuf  <= rel_go ? rel_n : ~rel_nbuf;
		end
	end
endmodule
`default_nettype wire
